// ===== src/das_ctrl.sv
// Command interpreter: status query, reset, self test and trigger arming
// Operation
// (RL1) Single query returns one digit per flag
// (RL2) Plain query returns five summary digits
// (RL3) Replies start with S, end CR LF
// (RL4) Reads repeat status until next command
// (RL5) Reset command restores power-up acquisition setup
// (RL6) Reset also restores clock, edges, delimiter
// (RL7) Self test runs all, then restores setup
// (RL8) Memory tests report errors 2 and 22
// (RL9) Address counter tests report 24 and 25
// (RL10) Comparator and extension tests report 26, 27
// (RL11) Status latch tests report 37, 38, 40
// (RL12) Record, complete, sample tests: 29, 36, 34
// (RL13) Power-up runs reduced quick self test
// (RL14) External arm used only when qualified
// (RL15) Suffix picks sequence; repeats until reset
// (RL16) Delay count defaults to memory depth
// (RL17) Arm only after command and external arm
// (RL18) Clear, configure, arm, then collect; the delayed arm skips the clear here as well
// (RL19) Arm-only never fires software trigger
// (RL20) Soft fire skips setup when armed
// (RL21) Delayed arm waits count, shows waiting
// (RL22) Fast arm skips memory clear
// (RL23) Invalid command sets error; valid clears (a valid query leaves it unchanged)
module das_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Acquisition status
  input wire logic extArmPin,
  input wire logic acqBusy,
  input wire logic trigSeen,
  input wire logic memFull,
  input wire logic rtUpdated,
  input wire logic sampleTick,
  // Arming handshakes
  input wire logic memClearDone,
  input wire logic cfgDone,
  output logic memClearReq,
  output logic cfgLoadReq,
  output logic trigArmed,
  output logic collectStart,
  output logic softFire,
  output logic waitInd,
  output logic extArmUse,
  // Self test engine
  input wire logic testDone,
  input wire logic testFail,
  output logic testReq,
  output logic testQuick,
  output logic [3:0] testIdx,
  output logic [19:0] testSpan,
  // Setup words to the acquisition hardware
  output logic [das_pkg::DAS_NUM_SETUP*32-1:0] setupWords
);
  import das_pkg::*;

  // Bus decode
  wire logic addrPhase = hsel & htrans[1] & hready;
  wire logic rdAccept = addrPhase & ~hwrite;
  wire logic wrAccept = addrPhase & hwrite;
  logic wrPend_ff;
  logic [7:0] wrAddr_ff;
  logic [31:0] rdData_ff;
  wire logic wrCmd = wrPend_ff & (wrAddr_ff == DAS_OFF_CMD);
  wire logic rdReply = rdAccept & (haddr[7:0] == DAS_OFF_REPLY);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdData_ff;

  // External arm pin synchroniser
  logic extSync1_ff;
  logic extSync2_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extSync1_ff <= 1'b0;
      extSync2_ff <= 1'b0;
    end else begin
      extSync1_ff <= extArmPin;
      extSync2_ff <= extSync1_ff;
    end
  end

  // Setup registers
  logic [31:0] setup_ff [DAS_NUM_SETUP];
  logic restoreSetup;
  genvar gi;
  generate
    for (gi = 0; gi < DAS_NUM_SETUP; gi++) begin : g_setup
      localparam logic [7:0] OFF = 8'(DAS_OFF_SETUP + 4 * gi);
      wire logic hit = wrPend_ff & (wrAddr_ff == OFF);
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          setup_ff[gi] <= DAS_SETUP_RST[gi];
        end else if (restoreSetup) begin
          setup_ff[gi] <= DAS_SETUP_RST[gi]; // RL5 RL6 RL7
        end else if (hit) begin
          setup_ff[gi] <= hwdata;
        end
      end
      assign setupWords[gi*32 +: 32] = setup_ff[gi];
    end
  endgenerate

  // Arm-in edge bit set means active high; clear means active low
  wire logic armEdgePos = setup_ff[2][DAS_S2_ARMEDGE];
  wire logic extActive = armEdgePos ? extSync2_ff : ~extSync2_ff;
  wire logic softMode = setup_ff[2][DAS_S2_SOFTMODE];

  // Command decode
  das_cmd_s cmd;
  assign cmd = das_cmd_s'(hwdata);
  das_state_e state_ff;
  das_state_e nxt_state;
  logic armed_ff;
  logic progErr_ff;
  logic selfFail_ff;
  logic [7:0] errCode_ff;
  logic [3:0] seqSub_ff;
  logic extUse_ff;
  logic [19:0] delayTarget_ff;
  logic [19:0] delayCnt_ff;
  logic [3:0] testIdx_ff;
  logic quick_ff;
  logic pwrTestPend_ff;
  logic doDelay_ff;
  logic doFire_ff;

  wire logic isIdle = (state_ff == DAS_ST_IDLE);
  wire logic opQuery = (cmd.op == DAS_OP_QUERY);
  wire logic opReset = (cmd.op == DAS_OP_RESET);
  wire logic opTest = (cmd.op == DAS_OP_SELFTEST);
  wire logic opTrig = (cmd.op == DAS_OP_TRIG);
  wire logic opRearm = (cmd.op == DAS_OP_REARM);
  wire logic subQueryOk = (cmd.sub <= DAS_Q_RTUPD);
  wire logic subTrigOk = (cmd.sub <= DAS_T_SOFT_FIRE);
  wire logic countOk = (cmd.count <= DAS_MEM_DEPTH); // RL16
  wire logic cmdValid = opQuery ? subQueryOk
                      : opReset ? 1'b1
                      : opTest ? isIdle
                      : opTrig ? (subTrigOk & countOk & isIdle)
                      : opRearm ? isIdle
                      : 1'b0;
  wire logic cmdGood = wrCmd & cmdValid;
  wire logic cmdBad = wrCmd & ~cmdValid;

  // Trigger command launches and stores its own sequence; rearm reuses it
  wire logic trigGo = cmdGood & (opTrig | opRearm);
  wire logic [3:0] goSub = opTrig ? cmd.sub : seqSub_ff; // RL15
  wire logic goExt = opTrig ? cmd.extArm : extUse_ff; // RL14
  wire logic [19:0] goCount = (opTrig & cmd.countGiven) ? cmd.count
                            : opTrig ? DAS_MEM_DEPTH : delayTarget_ff; // RL16
  wire logic fireOnly = (goSub == DAS_T_SOFT_FIRE) & armed_ff; // RL20
  wire logic goClear = (goSub == DAS_T_NONE) | (goSub == DAS_T_ARM_ONLY)
                     | (goSub == DAS_T_SOFT_FIRE); // RL18 RL22
  wire logic goDelay = (goSub == DAS_T_DELAYED); // RL21
  wire logic goFire = ((goSub == DAS_T_NONE) & softMode)
                    | (goSub == DAS_T_SOFT_FIRE); // RL19 RL20
  wire logic resetCmd = cmdGood & opReset;
  wire logic testGo = (cmdGood & opTest) | (pwrTestPend_ff & isIdle);
  wire logic lastTest = (testIdx_ff == 4'(DAS_NUM_TESTS - 1));
  wire logic delayDone = (delayCnt_ff >= delayTarget_ff);

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DAS_ST_IDLE: begin
        if (testGo) begin
          nxt_state = DAS_ST_TEST;
        end else if (trigGo & fireOnly) begin
          nxt_state = DAS_ST_FIRE; // RL20
        end else if (trigGo) begin
          nxt_state = goClear ? DAS_ST_CLEAR : DAS_ST_CONFIG; // RL18 RL22
        end
      end
      DAS_ST_CLEAR: nxt_state = memClearDone ? DAS_ST_CONFIG : state_ff;
      DAS_ST_CONFIG: nxt_state = !cfgDone ? state_ff : doDelay_ff ? DAS_ST_DELAY : DAS_ST_EXTW;
      DAS_ST_DELAY: nxt_state = delayDone ? DAS_ST_EXTW : state_ff; // RL21
      DAS_ST_EXTW: nxt_state = (!extUse_ff || extActive) ? DAS_ST_ARM : state_ff; // RL17
      DAS_ST_ARM: nxt_state = DAS_ST_COLLECT;
      DAS_ST_COLLECT: nxt_state = doFire_ff ? DAS_ST_FIRE : DAS_ST_IDLE;
      DAS_ST_FIRE: nxt_state = DAS_ST_IDLE;
      DAS_ST_TEST: nxt_state = (testDone && lastTest) ? DAS_ST_IDLE : state_ff;
      default: nxt_state = DAS_ST_IDLE;
    endcase
    if (resetCmd) begin
      nxt_state = DAS_ST_IDLE;
    end
  end

  assign restoreSetup = resetCmd | ((state_ff == DAS_ST_TEST) & testDone & lastTest);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= DAS_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Sequence plan held for the running and later arm commands
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seqSub_ff <= DAS_T_NONE;
      extUse_ff <= 1'b0;
      delayTarget_ff <= DAS_MEM_DEPTH;
      doDelay_ff <= 1'b0;
      doFire_ff <= 1'b0;
    end else if (resetCmd) begin
      seqSub_ff <= DAS_T_NONE; // RL15
      extUse_ff <= 1'b0;
      delayTarget_ff <= DAS_MEM_DEPTH;
    end else if (trigGo && isIdle) begin
      seqSub_ff <= goSub; // RL15
      extUse_ff <= goExt; // RL14
      delayTarget_ff <= goCount; // RL16
      doDelay_ff <= goDelay;
      doFire_ff <= goFire;
    end
  end

  // Armed state and delay counting
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed_ff <= 1'b0;
    end else if (resetCmd || testGo || trigSeen) begin
      armed_ff <= 1'b0;
    end else if (state_ff == DAS_ST_ARM) begin
      armed_ff <= 1'b1; // RL17 RL18
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      delayCnt_ff <= 20'h00000;
    end else if (state_ff != DAS_ST_DELAY) begin
      delayCnt_ff <= 20'h00000;
    end else if (sampleTick && !delayDone) begin
      delayCnt_ff <= delayCnt_ff + 20'h00001; // RL21
    end
  end

  // Programming error flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      progErr_ff <= 1'b0;
    end else if (cmdBad) begin
      progErr_ff <= 1'b1; // RL23
    end else if (cmdGood && !opQuery) begin
      progErr_ff <= 1'b0; // RL23
    end
  end

  // Self test stepping and first failing error number
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwrTestPend_ff <= 1'b1;
      quick_ff <= 1'b1;
      testIdx_ff <= 4'h0;
      selfFail_ff <= 1'b0;
      errCode_ff <= 8'h00;
    end else if (testGo && isIdle) begin
      pwrTestPend_ff <= 1'b0;
      quick_ff <= pwrTestPend_ff; // RL13
      testIdx_ff <= 4'h0;
      selfFail_ff <= 1'b0;
      errCode_ff <= 8'h00;
    end else if (state_ff == DAS_ST_TEST && testDone) begin
      testIdx_ff <= lastTest ? 4'h0 : testIdx_ff + 4'h1; // RL7
      if (testFail) begin
        selfFail_ff <= 1'b1;
        if (!selfFail_ff) begin
          errCode_ff <= DAS_TEST_CODE[testIdx_ff]; // RL8 RL9 RL10 RL11 RL12
        end
      end
    end
  end

  assign testReq = (state_ff == DAS_ST_TEST);
  assign testQuick = quick_ff;
  assign testIdx = testIdx_ff;
  assign testSpan = quick_ff ? DAS_SPAN_QUICK[testIdx_ff]
                             : DAS_SPAN_FULL[testIdx_ff]; // RL8 RL13

  assign memClearReq = (state_ff == DAS_ST_CLEAR); // RL18
  assign cfgLoadReq = (state_ff == DAS_ST_CONFIG);
  assign trigArmed = armed_ff;
  assign collectStart = (state_ff == DAS_ST_COLLECT); // RL18
  assign softFire = (state_ff == DAS_ST_FIRE); // RL19 RL20
  assign waitInd = (state_ff == DAS_ST_DELAY) | (state_ff == DAS_ST_EXTW); // RL21
  assign extArmUse = extUse_ff; // RL14

  // Live status
  das_stat_s stat;
  assign stat = '{selfFail: selfFail_ff, progErr: progErr_ff, inProg: acqBusy,
                  trig: trigSeen, memFull: memFull, rtUpd: rtUpdated};

  // Status reply stream
  logic replyOn_ff;
  logic [3:0] replySel_ff;
  logic [2:0] replyIdx_ff;
  wire logic replyAll = (replySel_ff == DAS_Q_ALL);
  wire logic [2:0] replyLast = replyAll ? DAS_LAST_ALL : DAS_LAST_ONE;
  wire logic [4:0] sumBits = {stat.selfFail, stat.progErr, stat.inProg, stat.trig, stat.memFull};
  logic oneBit;
  logic [7:0] replyChar;

  always_comb begin
    case (replySel_ff)
      DAS_Q_SELF: oneBit = stat.selfFail;
      DAS_Q_ERR: oneBit = stat.progErr;
      DAS_Q_PROG: oneBit = stat.inProg;
      DAS_Q_TRIG: oneBit = stat.trig;
      DAS_Q_FULL: oneBit = stat.memFull;
      DAS_Q_RTUPD: oneBit = stat.rtUpd;
      default: oneBit = 1'b0;
    endcase
  end

  always_comb begin
    if (replyIdx_ff == 3'h0) begin
      replyChar = DAS_CH_S; // RL3
    end else if (replyIdx_ff == replyLast) begin
      replyChar = DAS_CH_LF; // RL3
    end else if (replyIdx_ff == replyLast - 3'h1) begin
      replyChar = DAS_CH_CR; // RL3
    end else if (replyAll) begin
      replyChar = DAS_CH_0 | {7'h00, sumBits[3'h5 - replyIdx_ff]}; // RL2
    end else begin
      replyChar = DAS_CH_0 | {7'h00, oneBit}; // RL1
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      replyOn_ff <= 1'b0;
      replySel_ff <= DAS_Q_ALL;
      replyIdx_ff <= 3'h0;
    end else if (cmdGood && opQuery) begin
      replyOn_ff <= 1'b1;
      replySel_ff <= cmd.sub;
      replyIdx_ff <= 3'h0;
    end else if (wrCmd) begin
      replyOn_ff <= 1'b0; // RL4
    end else if (rdReply && replyOn_ff) begin
      replyIdx_ff <= (replyIdx_ff == replyLast) ? 3'h0 : replyIdx_ff + 3'h1; // RL4
    end
  end

  // Read mux, registered in the address phase
  wire logic [7:0] rdOff = haddr[7:0];
  wire logic setupHit = (rdOff >= DAS_OFF_SETUP)
                      & (rdOff < 8'(DAS_OFF_SETUP + 4 * DAS_NUM_SETUP))
                      & (rdOff[1:0] == 2'h0);
  wire logic [2:0] setupSel = 3'((rdOff - DAS_OFF_SETUP) >> 2);
  wire logic [31:0] statusWord = {16'h0000, 7'h00, armed_ff, waitInd, ~isIdle, stat};
  logic [31:0] rdMux;

  always_comb begin
    rdMux = 32'h00000000;
    if (rdOff == DAS_OFF_REPLY) begin
      rdMux = replyOn_ff ? {24'h000000, replyChar} : 32'h00000000;
    end else if (rdOff == DAS_OFF_STATUS) begin
      rdMux = statusWord;
    end else if (rdOff == DAS_OFF_ERRCODE) begin
      rdMux = {24'h000000, errCode_ff};
    end else if (setupHit) begin
      rdMux = setup_ff[setupSel];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
      rdData_ff <= 32'h00000000;
    end else begin
      wrPend_ff <= wrAccept;
      wrAddr_ff <= haddr[7:0];
      if (rdAccept) begin
        rdData_ff <= rdMux;
      end
    end
  end
endmodule

// ===== src/das_pkg.sv
// Shared constants and types for the digitizer command block
package das_pkg;
  localparam int unsigned DAS_CLK_HZ = 10000000;
  localparam logic [19:0] DAS_MEM_DEPTH = 20'h40000;
  // Byte offsets on the register bus
  localparam logic [7:0] DAS_OFF_CMD = 8'h00;
  localparam logic [7:0] DAS_OFF_REPLY = 8'h04;
  localparam logic [7:0] DAS_OFF_STATUS = 8'h08;
  localparam logic [7:0] DAS_OFF_ERRCODE = 8'h0C;
  localparam logic [7:0] DAS_OFF_SETUP = 8'h10;
  localparam int unsigned DAS_NUM_SETUP = 6;
  // Command opcodes
  localparam logic [3:0] DAS_OP_QUERY = 4'h1;
  localparam logic [3:0] DAS_OP_RESET = 4'h2;
  localparam logic [3:0] DAS_OP_SELFTEST = 4'h3;
  localparam logic [3:0] DAS_OP_TRIG = 4'h4;
  localparam logic [3:0] DAS_OP_REARM = 4'h5;
  // Query selectors
  localparam logic [3:0] DAS_Q_ALL = 4'h0;
  localparam logic [3:0] DAS_Q_SELF = 4'h1;
  localparam logic [3:0] DAS_Q_ERR = 4'h2;
  localparam logic [3:0] DAS_Q_PROG = 4'h3;
  localparam logic [3:0] DAS_Q_TRIG = 4'h4;
  localparam logic [3:0] DAS_Q_FULL = 4'h5;
  localparam logic [3:0] DAS_Q_RTUPD = 4'h6;
  // Trigger suffixes
  localparam logic [3:0] DAS_T_NONE = 4'h0;
  localparam logic [3:0] DAS_T_ARM_ONLY = 4'h1;
  localparam logic [3:0] DAS_T_DELAYED = 4'h2;
  localparam logic [3:0] DAS_T_FAST = 4'h3;
  localparam logic [3:0] DAS_T_SOFT_FIRE = 4'h4;
  // Reply characters
  localparam logic [7:0] DAS_CH_S = 8'h53;
  localparam logic [7:0] DAS_CH_0 = 8'h30;
  localparam logic [7:0] DAS_CH_CR = 8'h0D;
  localparam logic [7:0] DAS_CH_LF = 8'h0A;
  localparam logic [2:0] DAS_LAST_ALL = 3'h7;
  localparam logic [2:0] DAS_LAST_ONE = 3'h3;
  // Setup word 2 field positions
  localparam int unsigned DAS_S2_SOFTMODE = 0;
  localparam int unsigned DAS_S2_ARMEDGE = 10;
  // Power-up setup words
  localparam logic [31:0] DAS_SETUP_RST [DAS_NUM_SETUP] = '{
    32'h0003FF9C, // collect count: depth minus 100, post-trigger
    32'h0064FF9C, // thresholds +100 / -100
    32'h3B0000F9, // soft mode, dc, 1M, single, BNC, int clk, edges neg, delim ';'
    32'h00989680, // sample clock 10 MHz
    32'h00000000, // delay 0
    32'h64000001  // range 100 V, update every 1 sample clock
  };
  // Self test sequence: error numbers and spans (full, power-up)
  localparam int unsigned DAS_NUM_TESTS = 13;
  localparam logic [7:0] DAS_TEST_CODE [DAS_NUM_TESTS] = '{
    8'h02, 8'h15, 8'h18, 8'h19, 8'h16, 8'h1A, 8'h1B, 8'h25, 8'h26, 8'h28, 8'h1D, 8'h24, 8'h22};
  localparam logic [19:0] DAS_SPAN_FULL [DAS_NUM_TESTS] = '{
    20'h08002, 20'h0, 20'h0, 20'h40000, 20'h40000, 20'h0, 20'h0,
    20'h0, 20'h0, 20'h0, 20'h0FEF6, 20'h0, 20'h0};
  localparam logic [19:0] DAS_SPAN_QUICK [DAS_NUM_TESTS] = '{
    20'h003E8, 20'h0, 20'h0, 20'h01004, 20'h003E8, 20'h0, 20'h0,
    20'h0, 20'h0, 20'h0, 20'h00104, 20'h0, 20'h0};

  typedef struct packed {
    logic [19:0] count;
    logic [1:0] spare;
    logic countGiven;
    logic extArm;
    logic [3:0] sub;
    logic [3:0] op;
  } das_cmd_s;

  typedef struct packed {
    logic selfFail;
    logic progErr;
    logic inProg;
    logic trig;
    logic memFull;
    logic rtUpd;
  } das_stat_s;

  typedef enum logic [8:0] {
    DAS_ST_IDLE = 9'h001,
    DAS_ST_CLEAR = 9'h002,
    DAS_ST_CONFIG = 9'h004,
    DAS_ST_DELAY = 9'h008,
    DAS_ST_EXTW = 9'h010,
    DAS_ST_ARM = 9'h020,
    DAS_ST_COLLECT = 9'h040,
    DAS_ST_FIRE = 9'h080,
    DAS_ST_TEST = 9'h100
  } das_state_e;
endpackage

// ===== verif/das_ctrl_assertions.sv
// Port-level checks for the digitizer command block
module das_ctrl_assertions
  import das_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Arming
  input wire logic memClearDone,
  input wire logic memClearReq,
  input wire logic cfgLoadReq,
  input wire logic trigArmed,
  input wire logic collectStart,
  input wire logic softFire,
  // Self test
  input wire logic testDone,
  input wire logic testReq,
  input wire logic testQuick,
  input wire logic [3:0] testIdx,
  input wire logic [19:0] testSpan
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence sClrEnd;
    memClearReq && memClearDone;
  endsequence
  sequence sLastStep;
    testReq && testDone && testIdx == 4'hC;
  endsequence
  clear_cfg_a: assert property (sClrEnd |=> cfgLoadReq)
    else $error("config step did not follow memory clear");
  step_excl_a: assert property (!(memClearReq && cfgLoadReq))
    else $error("clear and config steps overlap");
  arm_collect_a: assert property ($rose(trigArmed) |-> ##[0:1] collectStart)
    else $error("arming without collection start");
  pulse_one_a: assert property (collectStart |=> !collectStart)
    else $error("collection start longer than one cycle");
  fire_cause_a: assert property (softFire |-> $past(collectStart) || $past(trigArmed))
    else $error("software trigger fired while not armed");
  test_excl_a: assert property (testReq |-> !memClearReq && !cfgLoadReq)
    else $error("arming steps during self test");
  test_end_a: assert property (sLastStep |-> ##[1:2] !testReq)
    else $error("self test did not end after last step");
  quick_span_a: assert property (testReq && testQuick && testIdx < 4'hD
    |-> testSpan == DAS_SPAN_QUICK[testIdx])
    else $error("power-up test span wrong");
  full_span_a: assert property (testReq && !testQuick && testIdx < 4'hD
    |-> testSpan == DAS_SPAN_FULL[testIdx])
    else $error("full test span wrong");
endmodule

bind das_ctrl das_ctrl_assertions chk (.clk(clk), .rstn(rstn),
  .memClearDone(memClearDone), .memClearReq(memClearReq), .cfgLoadReq(cfgLoadReq),
  .trigArmed(trigArmed), .collectStart(collectStart), .softFire(softFire),
  .testDone(testDone), .testReq(testReq), .testQuick(testQuick), .testIdx(testIdx),
  .testSpan(testSpan));

// ===== verif/das_acq_model.sv
// Acquisition and self test engine model answering the block's handshakes
module das_acq_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Requests from the block
  input wire logic memClearReq,
  input wire logic cfgLoadReq,
  input wire logic testReq,
  input wire logic [3:0] testIdx,
  // Response shaping from the bench
  input wire logic [1:0] lat,
  input wire logic [4:0] failStep,
  // Answers
  output logic memClearDone,
  output logic cfgDone,
  output logic testDone,
  output logic testFail,
  output logic sampleTick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] req;
  logic [2:0] done;
  logic [5:0] cnt;
  logic [1:0] tickCnt;
  assign req = {testReq, cfgLoadReq, memClearReq};
  assign {testDone, cfgDone, memClearDone} = done;
  assign testFail = testDone && {1'b0, testIdx} == failStep;
  assign sampleTick = tickCnt == 2'h2;
  // Each request answered after lat+1 cycles with a one-cycle done
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done <= 3'h0;
      cnt <= 6'h0;
      tickCnt <= 2'h0;
    end else begin
      tickCnt <= (tickCnt == 2'h2) ? 2'h0 : tickCnt + 2'h1;
      for (int i = 0; i < 3; i++) begin
        if (!req[i] || done[i]) begin
          done[i] <= 1'b0;
          cnt[2*i+:2] <= 2'h0;
        end else if (cnt[2*i+:2] == lat) begin
          done[i] <= 1'b1;
        end else begin
          cnt[2*i+:2] <= cnt[2*i+:2] + 2'h1;
        end
      end
    end
  end
endmodule

// ===== verif/digitizer_arm_status_selftest_test.sv
// Self-checking bench for the digitizer command block
module digitizer_arm_status_selftest_test;
  timeunit 1ns;
  timeprecision 1ns;
  import das_pkg::*;
  logic clk, rstn, hsel, hwrite, extArmPin, acqBusy, trigSeen, memFull, rtUpdated;
  logic hreadyout, hresp, memClearReq, cfgLoadReq, trigArmed, collectStart, softFire;
  logic waitInd, extArmUse, testReq, testQuick, memClearDone, cfgDone, testDone;
  logic testFail, sampleTick, expSelf, expErr, pClr, seenW;
  logic [31:0] haddr, hwdata, hrdata, rdv, seed, d;
  logic [1:0] htrans, lat;
  logic [2:0] hsize;
  logic [3:0] testIdx;
  logic [4:0] failStep;
  logic [19:0] testSpan;
  logic [DAS_NUM_SETUP*32-1:0] setupWords;
  int err_count, n_checks, nClr, nFire, nTick, cyc, fs;
  int eClr [5] = '{1, 1, 0, 0, 0};
  int eFire [5] = '{1, 0, 0, 0, 1};
  logic [3:0] badOp [3] = '{4'h9, 4'h4, 4'h4};
  logic [3:0] badSub [3] = '{4'h0, 4'h7, 4'h2};

  das_ctrl DUT (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .extArmPin, .acqBusy, .trigSeen,
    .memFull, .rtUpdated, .sampleTick, .memClearDone, .cfgDone, .memClearReq,
    .cfgLoadReq, .trigArmed, .collectStart, .softFire, .waitInd, .extArmUse, .testDone,
    .testFail, .testReq, .testQuick, .testIdx, .testSpan, .setupWords);
  das_acq_model acq (.clk, .rstn, .memClearReq, .cfgLoadReq, .testReq, .testIdx, .lat,
    .failStep, .memClearDone, .cfgDone, .testDone, .testFail, .sampleTick);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  // One single AHB-Lite transfer; read data lands in rdv
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdv);
    chk("hresp", 0, hresp);
  endtask

  task automatic cmd(input logic [3:0] op, sub, input logic ext, gv, input logic [19:0] n);
    bus(1'b1, DAS_OFF_CMD, das_cmd_s'{n, 2'b00, gv, ext, sub, op});
    @(posedge clk);
  endtask

  // Poll until sequencer and test engine are quiet
  task automatic idle();
    do bus(1'b0, DAS_OFF_STATUS, 32'h0); while (rdv[6] !== 1'b0 || testReq !== 1'b0);
  endtask

  task automatic query(input logic [3:0] sub);
    logic [7:0] q [$];
    logic [5:0] f;
    f = {rtUpdated, memFull, trigSeen, acqBusy, expErr, expSelf};
    q = '{DAS_CH_S};
    if (sub == DAS_Q_ALL) for (int i = 0; i < 5; i++) q.push_back(DAS_CH_0 | 8'(f[i]));
    else q.push_back(DAS_CH_0 | 8'(f[sub-1]));
    q.push_back(DAS_CH_CR);
    q.push_back(DAS_CH_LF);
    cmd(DAS_OP_QUERY, sub, 1'b0, 1'b0, 20'h0);
    foreach (q[i]) rd("reply", DAS_OFF_REPLY, {24'h0, q[i]});
    rd("reply repeat", DAS_OFF_REPLY, {24'h0, DAS_CH_S});
  endtask

  task automatic disarm();
    trigSeen <= 1'b1;
    @(posedge clk);
    trigSeen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic arm(input logic [3:0] op, sub, input int ec, ef, input logic [19:0] n);
    nClr = 0;
    nFire = 0;
    nTick = 0;
    seenW = 1'b0;
    lat <= 2'(rnd());
    cmd(op, sub, 1'b0, sub == DAS_T_DELAYED, n);
    idle();
    chk("armed", 1, trigArmed);
    chk("clears", ec, nClr);
    if (ef >= 0) chk("fires", ef, nFire);
    if (sub == DAS_T_DELAYED) chk("wait shown", 1, seenW);
    if (sub == DAS_T_DELAYED) chk("ticks", 1, nTick >= n);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (memClearReq === 1'b1 && !pClr) nClr++;
    pClr <= memClearReq === 1'b1;
    if (softFire === 1'b1) nFire++;
    if (waitInd === 1'b1) seenW = 1'b1;
    if (waitInd === 1'b1 && sampleTick) nTick++;
    if (cyc == 30000) begin
      err_count++;
      results();
    end
  end

  initial begin
    {seed, rstn, hsel, haddr, htrans, hwrite, hwdata} = {32'hF2F9, 69'h0};
    {acqBusy, trigSeen, memFull, rtUpdated, lat, failStep} = {6'h0, 5'h1F};
    {hsize, extArmPin, expSelf, expErr, pClr, seenW} = {3'h2, 5'h10};
    {err_count, n_checks, nClr, nFire, nTick, cyc} = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("quick test", 1, testQuick);
    idle();
    rd("errcode", DAS_OFF_ERRCODE, 32'h0);
    for (int i = 0; i < DAS_NUM_SETUP; i++) begin
      d = rnd();
      rd("setup", DAS_OFF_SETUP + 8'(4*i), DAS_SETUP_RST[i]);
      bus(1'b1, DAS_OFF_SETUP + 8'(4*i), d);
      rd("setup rw", DAS_OFF_SETUP + 8'(4*i), d);
    end
    cmd(DAS_OP_RESET, 4'h0, 1'b0, 1'b0, 20'h0);
    for (int i = 0; i < DAS_NUM_SETUP; i++) begin
      rd("setup", DAS_OFF_SETUP + 8'(4*i), DAS_SETUP_RST[i]);
      chk("setup out", DAS_SETUP_RST[i], setupWords[32*i+:32]);
    end
    for (int r = 0; r < 4; r++) begin
      {acqBusy, trigSeen, memFull, rtUpdated} <= 4'(rnd());
      @(posedge clk);
      for (int s = 0; s < 7; s++) query(4'(s));
    end
    {acqBusy, trigSeen, memFull, rtUpdated} <= 4'h0;
    for (int b = 0; b < 3; b++) begin
      cmd(DAS_OP_RESET, 4'h0, 1'b0, 1'b0, 20'h0);
      expErr = 1'b0;
      cmd(badOp[b], badSub[b], 1'b0, b == 2, DAS_MEM_DEPTH + 20'h1);
      expErr = 1'b1;
      query(DAS_Q_ERR);
      chk("refused arm", 0, trigArmed);
    end
    cmd(DAS_OP_RESET, 4'h0, 1'b0, 1'b0, 20'h0);
    expErr = 1'b0;
    // Trigger input stays quiet until all five suffixes are armed
    for (int s = 0; s < 5; s++) arm(DAS_OP_TRIG, 4'(s), eClr[s], eFire[s], 20'(rnd() % 8));
    disarm();
    arm(DAS_OP_TRIG, DAS_T_SOFT_FIRE, 1, 1, 20'h0);
    disarm();
    arm(DAS_OP_TRIG, DAS_T_ARM_ONLY, 1, 0, 20'h0);
    disarm();
    arm(DAS_OP_REARM, 4'h0, 1, 0, 20'h0);
    chk("ext use", 0, extArmUse);
    cmd(DAS_OP_RESET, 4'h0, 1'b0, 1'b0, 20'h0);
    arm(DAS_OP_REARM, 4'h0, 1, 1, 20'h0);
    disarm();
    cmd(DAS_OP_TRIG, DAS_T_ARM_ONLY, 1'b1, 1'b0, 20'h0);
    repeat (20) @(posedge clk);
    chk("ext wait", 1, waitInd);
    chk("ext early", 0, trigArmed);
    chk("ext use", 1, extArmUse);
    extArmPin <= 1'b0;
    idle();
    chk("ext armed", 1, trigArmed);
    extArmPin <= 1'b1;
    fs = rnd() % 13;
    failStep <= 5'(fs);
    bus(1'b1, DAS_OFF_SETUP, rnd());
    cmd(DAS_OP_SELFTEST, 4'h0, 1'b0, 1'b0, 20'h0);
    chk("full test", 0, testQuick);
    idle();
    expSelf = 1'b1;
    rd("errcode", DAS_OFF_ERRCODE, {24'h0, DAS_TEST_CODE[fs]});
    rd("setup after test", DAS_OFF_SETUP, DAS_SETUP_RST[0]);
    query(DAS_Q_SELF);
    results();
  end
endmodule
